// ---- design/cpuc_pkg.sv ----
// Purpose: shared constants and types of the cpu control block
// Assumes: 8-bit core, 16-bit address space, apb register window
// Notes: psw bit positions and reset values live here only
package cpuc_pkg;
  // ----------------------------------------
  // reset values and fixed addresses
  // ----------------------------------------
  localparam logic [15:0] VEC_ADDR = 16'h0000;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] GPR_MEM_BASE = 16'hfee0;
  // ----------------------------------------
  // status word bit positions
  // ----------------------------------------
  localparam int PSW_IE = 7;
  localparam int PSW_Z = 6;
  localparam int PSW_BANK_SELECT_HIGH = 5;
  localparam int PSW_AC = 4;
  localparam int PSW_BANK_SELECT_LOW = 3;
  localparam int PSW_ISP = 1;
  localparam int PSW_CY = 0;
  // ----------------------------------------
  // apb map
  // ----------------------------------------
  localparam logic [11:0] A_PSW = 12'h000;
  localparam logic [11:0] A_SP = 12'h004;
  localparam logic [11:0] A_PC = 12'h008;
  localparam logic [11:0] A_STAT = 12'h00c;
  localparam logic [4:0] A_GPR_PAGE = 5'h01;
  // ----------------------------------------
  // stack and vector sequence lengths, as last byte index
  // ----------------------------------------
  localparam logic [1:0] LAST_ONE = 2'h0;
  localparam logic [1:0] LAST_TWO = 2'h1;
  localparam logic [1:0] LAST_THREE = 2'h2;
  typedef enum logic [3:0] {
    CMD_NONE = 4'b0000, CMD_ADVANCE = 4'b0001, CMD_BRANCH = 4'b0010,
    CMD_DI = 4'b0011, CMD_EI = 4'b0100, CMD_SEL_BANK = 4'b0101,
    CMD_ARITH = 4'b0110, CMD_ROTATE = 4'b0111, CMD_BIT_CY = 4'b1000,
    CMD_PUSH_PSW = 4'b1001, CMD_POP_PSW = 4'b1010, CMD_INT_ACK = 4'b1011,
    CMD_BREAK = 4'b1100, CMD_INT_RET = 4'b1101, CMD_BRK_RET = 4'b1110,
    CMD_SP_LOAD = 4'b1111
  } cpuc_cmd_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_VEC = 2'b01, S_PUSH = 2'b10, S_POP = 2'b11
  } cpuc_seq_t;
endpackage : cpuc_pkg

// ---- design/cpuc_top.sv ----
// Purpose: next-fetch pointer, status word, stack pointer, register banks
// Assumes: core issues one command per cycle while busy is low
// Notes: stack and vector bytes move over a req/ack byte memory port
// Contract
// - Next-fetch pointer is 16 bits and advances by instruction length.
// - Branch loads next-fetch pointer with given target.
// - After reset pointer is loaded from bytes at 0000H and 0001H.
// - Status word is eight flag bits, 02H after reset.
// - Status word pushed on interrupt or push, restored on returns or pop.
// - Interrupt enable low refuses every interrupt request.
// - Enable high: acceptance uses service level, mask and priority.
// - Interrupt off and acknowledge clear enable; interrupt on sets it.
// - Zero flag set for zero result, cleared otherwise.
// - Two bank select bits choose a bank; bank switch writes them.
// - Half carry set on carry from or borrow at bit 3.
// - Service level low blocks low priority vectored requests.
// - Carry holds add/sub overflow, rotate shift-out, bit accumulator.
// - Stack pointer is 16 bits; software keeps stack in fast RAM.
// - Stack pointer decrements before write, increments after read.
// - Registers occupy FEE0H to FEFFH as four banks of eight bytes; here they sit in an internal array, reached over APB at 080H to 0FCH.
// - Bytes usable alone or as four fixed 16-bit pairs.
// - Registers addressed by byte index 0 to 7, pair 0 to 3.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module cpuc_top
  import cpuc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cmd_valid,
  input wire cpuc_cmd_t cmd,
  input wire logic [2:0] cmd_len,
  input wire logic [15:0] cmd_addr,
  input wire logic [1:0] cmd_bank,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic alu_sub,
  input wire logic cmd_bit,
  input wire logic irq_req,
  input wire logic irq_masked,
  input wire logic irq_low_pri,
  output logic irq_accept,
  input wire logic gpr_we,
  input wire logic gpr_wpair,
  input wire logic [2:0] gpr_wsel,
  input wire logic [15:0] gpr_wdata,
  input wire logic gpr_rpair,
  input wire logic [2:0] gpr_rsel,
  output logic [15:0] gpr_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic [15:0] pc_out,
  output logic [7:0] psw_out,
  output logic [15:0] sp_out,
  output logic busy
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] program_status_word;
    logic [15:0] sp;
    logic [31:0][7:0] gpr;
    cpuc_seq_t seq;
    logic [1:0] cnt;
    logic [1:0] last;
    logic [7:0] saved_psw;
    logic [15:0] saved_pc;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic busy;
    logic irq_accept;
    logic [15:0] gpr_rdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } cpuc_state_t;

  localparam cpuc_state_t ST_RESET = '{
    pc: PC_RESET, program_status_word: PSW_RESET, sp: SP_RESET, gpr: '0,
    seq: S_VEC, cnt: 2'h0, last: LAST_TWO, saved_psw: 8'h00,
    saved_pc: 16'h0000, mem_req: 1'b0, mem_we: 1'b0,
    mem_addr: 16'h0000, mem_wdata: 8'h00, busy: 1'b1,
    irq_accept: 1'b0, gpr_rdata: 16'h0000, pready: 1'b0,
    prdata: 32'h0000_0000, pslverr: 1'b0
  };

  cpuc_state_t r_reg;
  cpuc_state_t r_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [8:0] arith_sum;
  logic [1:0] bank;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // bank 0 at the top block, higher banks descend
  function automatic logic [4:0] gidx(input logic [1:0] b, input logic [2:0] rn);
    return {~b, rn};
  endfunction : gidx

  function automatic logic half_carry(input logic [7:0] a, input logic [7:0] b,
                                      input logic sub);
    logic [4:0] s;
    s = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
    return s[4];
  endfunction : half_carry

  function automatic logic map_ok(input logic [11:0] a);
    return (a == A_PSW) || (a == A_SP) || (a == A_PC) || (a == A_STAT) ||
           ((a[11:7] == A_GPR_PAGE) && (a[1:0] == 2'h0));
  endfunction : map_ok

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign arith_sum = alu_sub ? ({1'b0, alu_a} - {1'b0, alu_b})
                             : ({1'b0, alu_a} + {1'b0, alu_b});
  assign bank = {r_reg.program_status_word[PSW_BANK_SELECT_HIGH], r_reg.program_status_word[PSW_BANK_SELECT_LOW]};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    // interrupt gate
    r_next.irq_accept = irq_req && r_reg.program_status_word[PSW_IE] && !irq_masked &&
                        (r_reg.program_status_word[PSW_ISP] || !irq_low_pri);
    // core commands, taken only while idle
    if (cmd_valid && (r_reg.seq == S_IDLE)) begin
      unique case (cmd)
        CMD_NONE: begin
        end
        CMD_ADVANCE: begin
          r_next.pc = r_reg.pc + {13'h0000, cmd_len};
        end
        CMD_BRANCH: begin
          r_next.pc = cmd_addr;
        end
        CMD_DI: begin
          r_next.program_status_word[PSW_IE] = 1'b0;
        end
        CMD_EI: begin
          r_next.program_status_word[PSW_IE] = 1'b1;
        end
        CMD_SEL_BANK: begin
          r_next.program_status_word[PSW_BANK_SELECT_HIGH] = cmd_bank[1];
          r_next.program_status_word[PSW_BANK_SELECT_LOW] = cmd_bank[0];
        end
        CMD_ARITH: begin
          r_next.program_status_word[PSW_Z] = (arith_sum[7:0] == 8'h00);
          r_next.program_status_word[PSW_AC] = half_carry(alu_a, alu_b, alu_sub);
          r_next.program_status_word[PSW_CY] = arith_sum[8];
        end
        CMD_ROTATE: begin
          r_next.program_status_word[PSW_CY] = cmd_bit;
        end
        CMD_BIT_CY: begin
          r_next.program_status_word[PSW_CY] = cmd_bit;
        end
        CMD_PUSH_PSW: begin
          r_next.saved_psw = r_reg.program_status_word;
          r_next.seq = S_PUSH;
          r_next.last = LAST_ONE;
          r_next.cnt = 2'h0;
        end
        CMD_POP_PSW: begin
          r_next.seq = S_POP;
          r_next.last = LAST_ONE;
          r_next.cnt = 2'h0;
        end
        CMD_INT_ACK, CMD_BREAK: begin
          r_next.saved_psw = r_reg.program_status_word;
          r_next.saved_pc = r_reg.pc;
          r_next.pc = cmd_addr;
          r_next.program_status_word[PSW_IE] = 1'b0;
          r_next.seq = S_PUSH;
          r_next.last = LAST_THREE;
          r_next.cnt = 2'h0;
        end
        CMD_INT_RET, CMD_BRK_RET: begin
          r_next.seq = S_POP;
          r_next.last = LAST_THREE;
          r_next.cnt = 2'h0;
        end
        CMD_SP_LOAD: begin
          r_next.sp = cmd_addr;
        end
      endcase
    end
    // byte sequencer for vector and stack traffic
    if (r_reg.seq != S_IDLE) begin
      if (!r_reg.mem_req) begin
        r_next.mem_req = 1'b1;
        r_next.mem_we = (r_reg.seq == S_PUSH);
        if (r_reg.seq == S_VEC) begin
          r_next.mem_addr = VEC_ADDR + {14'h0000, r_reg.cnt};
        end else if (r_reg.seq == S_PUSH) begin
          r_next.sp = r_reg.sp - 16'h0001;
          r_next.mem_addr = r_reg.sp - 16'h0001;
          if (r_reg.cnt == 2'h0) begin
            r_next.mem_wdata = r_reg.saved_psw;
          end else if (r_reg.cnt == 2'h1) begin
            r_next.mem_wdata = r_reg.saved_pc[15:8];
          end else begin
            r_next.mem_wdata = r_reg.saved_pc[7:0];
          end
        end else begin
          r_next.mem_addr = r_reg.sp;
        end
      end else if (mem_ack) begin
        r_next.mem_req = 1'b0;
        r_next.mem_we = 1'b0;
        if (r_reg.seq == S_VEC) begin
          if (r_reg.cnt == 2'h0) begin
            r_next.pc[7:0] = mem_rdata;
          end else begin
            r_next.pc[15:8] = mem_rdata;
          end
        end else if (r_reg.seq == S_POP) begin
          r_next.sp = r_reg.sp + 16'h0001;
          if ((r_reg.last == LAST_ONE) || (r_reg.cnt == 2'h2)) begin
            r_next.program_status_word = mem_rdata;
          end else if (r_reg.cnt == 2'h0) begin
            r_next.pc[7:0] = mem_rdata;
          end else begin
            r_next.pc[15:8] = mem_rdata;
          end
        end
        r_next.cnt = r_reg.cnt + 2'h1;
        if (r_reg.cnt == r_reg.last) begin
          r_next.seq = S_IDLE;
          r_next.cnt = 2'h0;
        end
      end
    end
    // register file, byte or pair, current bank
    if (gpr_we) begin
      if (gpr_wpair) begin
        r_next.gpr[gidx(bank, {gpr_wsel[1:0], 1'b0})] = gpr_wdata[7:0];
        r_next.gpr[gidx(bank, {gpr_wsel[1:0], 1'b1})] = gpr_wdata[15:8];
      end else begin
        r_next.gpr[gidx(bank, gpr_wsel)] = gpr_wdata[7:0];
      end
    end
    if (gpr_rpair) begin
      r_next.gpr_rdata = {r_reg.gpr[gidx(bank, {gpr_rsel[1:0], 1'b1})],
                          r_reg.gpr[gidx(bank, {gpr_rsel[1:0], 1'b0})]};
    end else begin
      r_next.gpr_rdata = {8'h00, r_reg.gpr[gidx(bank, gpr_rsel)]};
    end
    // apb slave, zero wait states
    r_next.pready = psel && !penable;
    if (psel && !penable) begin
      r_next.pslverr = !map_ok(paddr);
      r_next.prdata = 32'h0000_0000;
      if (paddr == A_PSW) begin
        r_next.prdata = {24'h000000, r_reg.program_status_word};
      end else if (paddr == A_SP) begin
        r_next.prdata = {16'h0000, r_reg.sp};
      end else if (paddr == A_PC) begin
        r_next.prdata = {16'h0000, r_reg.pc};
      end else if (paddr == A_STAT) begin
        r_next.prdata = {29'h00000000, bank, r_reg.busy};
      end else if (paddr[11:7] == A_GPR_PAGE) begin
        r_next.prdata = {24'h000000, r_reg.gpr[paddr[6:2]]};
      end
    end
    // software writes land last and win
    if (psel && penable && r_reg.pready && pwrite && !r_reg.pslverr) begin
      if ((paddr == A_PSW) && pstrb[0]) begin
        r_next.program_status_word = pwdata[7:0];
      end else if (paddr == A_SP) begin
        if (pstrb[0]) begin
          r_next.sp[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
          r_next.sp[15:8] = pwdata[15:8];
        end
      end else if ((paddr[11:7] == A_GPR_PAGE) && pstrb[0]) begin
        r_next.gpr[paddr[6:2]] = pwdata[7:0];
      end
    end
    r_next.busy = (r_next.seq != S_IDLE);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= ST_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pready = r_reg.pready;
  assign prdata = r_reg.prdata;
  assign pslverr = r_reg.pslverr;
  assign irq_accept = r_reg.irq_accept;
  assign gpr_rdata = r_reg.gpr_rdata;
  assign mem_req = r_reg.mem_req;
  assign mem_we = r_reg.mem_we;
  assign mem_addr = r_reg.mem_addr;
  assign mem_wdata = r_reg.mem_wdata;
  assign pc_out = r_reg.pc;
  assign psw_out = r_reg.program_status_word;
  assign sp_out = r_reg.sp;
  assign busy = r_reg.busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = cmd_valid && !r_reg.busy;

  pc_advance_a: assert property (
    take && cmd == CMD_ADVANCE && !(psel && penable)
    |=> r_reg.pc == $past(r_reg.pc) + {13'h0000, $past(cmd_len)})
    else $error("pointer did not advance by length");
  pc_branch_a: assert property (
    take && cmd == CMD_BRANCH |=> r_reg.pc == $past(cmd_addr))
    else $error("branch target not loaded");
  vector_fetch_a: assert property (
    r_reg.seq == S_VEC && r_reg.mem_req |-> !r_reg.mem_we &&
    r_reg.mem_addr == VEC_ADDR + {14'h0000, r_reg.cnt})
    else $error("vector read address wrong");
  psw_reset_a: assert property (
    $rose(rst_n) |-> r_reg.program_status_word == PSW_RESET)
    else $error("status word reset value wrong");
  irq_refuse_a: assert property (
    !r_reg.program_status_word[PSW_IE] |=> !r_reg.irq_accept)
    else $error("request accepted while disabled");
  low_prio_a: assert property (
    !r_reg.program_status_word[PSW_ISP] && irq_low_pri |=> !r_reg.irq_accept)
    else $error("low priority accepted at low service level");
  ack_clears_ie_a: assert property (
    take && cmd == CMD_INT_ACK && !(psel && penable)
    |=> !r_reg.program_status_word[PSW_IE] ##1 r_reg.seq == S_PUSH && r_reg.mem_req)
    else $error("acknowledge did not clear enable");
  zero_flag_a: assert property (
    take && cmd == CMD_ARITH && !(psel && penable)
    |=> r_reg.program_status_word[PSW_Z] == ($past(arith_sum[7:0]) == 8'h00))
    else $error("zero flag wrong");
  push_predec_a: assert property (
    $rose(r_reg.mem_req) && r_reg.mem_we |-> r_reg.mem_addr == r_reg.sp &&
    r_reg.sp == $past(r_reg.sp) - 16'h0001)
    else $error("stack write not pre-decremented");
  push_three_a: assert property (
    take && cmd == CMD_BREAK |=> r_reg.last == LAST_THREE &&
    r_reg.saved_psw == $past(r_reg.program_status_word))
    else $error("break entry not three bytes");

  int_entry_c: cover property (take && cmd == CMD_INT_ACK ##[1:40] !r_reg.busy);
  int_return_c: cover property (take && cmd == CMD_INT_RET ##[1:40] !r_reg.busy);
  vector_done_c: cover property ($fell(r_reg.busy) && r_reg.seq == S_IDLE);
  apb_write_c: cover property (psel && penable && r_reg.pready && pwrite);
endmodule : cpuc_top

// ---- sim/test_cpu_control_and_gp_registers.sv ----
// Purpose: self-checking bench for the cpu control and register block
// Assumes: apb slave with zero wait, byte memory answered by the bench
// Notes: stack bytes land in a bench array and are compared by value
`timescale 1ns/1ps
module test_cpu_control_and_gp_registers
  import cpuc_pkg::*;
;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  localparam logic [31:0] TA = 32'h22ff1005;
  localparam logic [31:0] TB = 32'h11010109;
  localparam logic [3:0] TS = 4'b0011;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic cmd_valid, alu_sub, cmd_bit, irq_req, irq_masked, irq_low_pri, irq_accept;
  cpuc_cmd_t cmd;
  logic [2:0] cmd_len, gpr_wsel, gpr_rsel;
  logic [15:0] cmd_addr, gpr_wdata, gpr_rdata, mem_addr, pc_out, sp_out;
  logic [1:0] cmd_bank;
  logic [7:0] alu_a, alu_b, mem_wdata, mem_rdata, psw_out;
  logic gpr_we, gpr_wpair, gpr_rpair, mem_req, mem_we, mem_ack, busy;
  logic [7:0] mem [0:65535];
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;

  always #4 core_clk = ~core_clk;

  cpuc_top uut (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_len(cmd_len),
    .cmd_addr(cmd_addr), .cmd_bank(cmd_bank), .alu_a(alu_a), .alu_b(alu_b),
    .alu_sub(alu_sub), .cmd_bit(cmd_bit), .irq_req(irq_req), .irq_masked(irq_masked),
    .irq_low_pri(irq_low_pri), .irq_accept(irq_accept), .gpr_we(gpr_we),
    .gpr_wpair(gpr_wpair), .gpr_wsel(gpr_wsel), .gpr_wdata(gpr_wdata),
    .gpr_rpair(gpr_rpair), .gpr_rsel(gpr_rsel), .gpr_rdata(gpr_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .pc_out(pc_out), .psw_out(psw_out),
    .sp_out(sp_out), .busy(busy)
  );

  // ----------------------------------------
  // byte memory and timeout
  // ----------------------------------------
  // read data only valid in the ack cycle, toggles otherwise
  always @(posedge core_clk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= (mem_req && !mem_ack) ? mem[mem_addr] : ~mem_rdata;
    if (mem_req && mem_ack && mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic go(input cpuc_cmd_t c, input logic [15:0] a);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_addr <= a;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge core_clk);
    end while (busy !== 1'b0);
  endtask : go

  task automatic gw(input logic p, input logic [2:0] s, input logic [15:0] d);
    @(posedge core_clk);
    gpr_we <= 1'b1;
    gpr_wpair <= p;
    gpr_wsel <= s;
    gpr_wdata <= d;
    @(posedge core_clk);
    gpr_we <= 1'b0;
  endtask : gw

  task automatic gr(input logic p, input logic [2:0] s, input logic [15:0] e);
    @(posedge core_clk);
    gpr_rpair <= p;
    gpr_rsel <= s;
    repeat (2) @(posedge core_clk);
    chk({16'h0, gpr_rdata}, {16'h0, e}, "register read");
  endtask : gr

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [7:0] ab, bb;
    logic sb;
    logic [8:0] r;
    logic [4:0] h;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = {15'h0, 32'h0, 4'hf};
    {cmd_valid, cmd_len, cmd_addr, cmd_bank, alu_a, alu_b, alu_sub, cmd_bit} = '0;
    cmd = CMD_NONE;
    {irq_req, irq_masked, irq_low_pri, gpr_we, gpr_wpair, gpr_wsel, gpr_wdata} = '0;
    {gpr_rpair, gpr_rsel} = '0;
    mem[16'h0000] = 8'h34;
    mem[16'h0001] = 8'h12;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    go(CMD_NONE, 16'h0);
    chk({16'h0, pc_out}, 32'h1234, "vector");
    chk({24'h0, psw_out}, 32'h02, "status reset");
    apb(1'b0, A_PSW, 32'h0);
    chk(rd, 32'h02, "status read");
    done("reset");
    cmd_len <= 3'h3;
    go(CMD_ADVANCE, 16'h0);
    chk({16'h0, pc_out}, 32'h1237, "advance");
    go(CMD_BRANCH, 16'h4000);
    chk({16'h0, pc_out}, 32'h4000, "branch");
    apb(1'b1, A_SP, 32'hfe20);
    apb(1'b0, A_SP, 32'h0);
    chk(rd, 32'hfe20, "sp read");
    apb(1'b1, A_PC, 32'hffff);
    chk({16'h0, pc_out}, 32'h4000, "pc write ignored");
    apb(1'b0, 12'h040, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000, "unmapped");
    done("apb");
    irq_req <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_PSW, {24'h0, 1'b1, 5'h0, i[2], 1'b0});
      irq_masked <= i[1];
      irq_low_pri <= i[0];
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq_accept}, {31'h0, !i[1] && (i[2] || !i[0])}, "accept");
    end
    irq_masked <= 1'b0;
    irq_low_pri <= 1'b0;
    go(CMD_DI, 16'h0);
    chk({31'h0, psw_out[7]}, 32'h0, "ie after off");
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq_accept}, 32'h0, "refused");
    go(CMD_EI, 16'h0);
    chk({31'h0, psw_out[7]}, 32'h1, "ie after on");
    irq_req <= 1'b0;
    done("interrupt gate");
    for (int i = 0; i < 4; i++) begin
      ab = TA[31 - 8 * i -: 8];
      bb = TB[31 - 8 * i -: 8];
      sb = TS[3 - i];
      alu_a <= ab;
      alu_b <= bb;
      alu_sub <= sb;
      go(CMD_ARITH, 16'h0);
      r = sb ? {1'b0, ab} - {1'b0, bb} : {1'b0, ab} + {1'b0, bb};
      h = sb ? {1'b0, ab[3:0]} - {1'b0, bb[3:0]} : {1'b0, ab[3:0]} + {1'b0, bb[3:0]};
      chk({29'h0, psw_out[6], psw_out[4], psw_out[0]}, {29'h0, r[7:0] == 8'h0, h[4], r[8]},
          "flags");
    end
    cmd_bit <= 1'b1;
    go(CMD_ROTATE, 16'h0);
    chk({31'h0, psw_out[0]}, 32'h1, "rotate carry");
    cmd_bit <= 1'b0;
    go(CMD_BIT_CY, 16'h0);
    chk({31'h0, psw_out[0]}, 32'h0, "bit carry");
    done("flags");
    for (int i = 0; i < 4; i++) begin
      cmd_bank <= 2'(i);
      go(CMD_SEL_BANK, 16'h0);
      chk({30'h0, psw_out[5], psw_out[3]}, 32'(i), "bank bits");
      apb(1'b0, A_STAT, 32'h0);
      chk({29'h0, rd[2:0]}, {29'h0, 2'(i), 1'b0}, "bank stat");
      gw(1'b0, 3'(i + 1), 16'(8'ha0 + i));
      apb(1'b0, 12'(12'h080 + 4 * ((3 - i) * 8 + i + 1)), 32'h0);
      chk(rd, 32'(8'ha0 + i), "bank memory");
      gr(1'b0, 3'(i + 1), 16'(8'ha0 + i));
    end
    gw(1'b1, 3'h1, 16'hbeef);
    gr(1'b1, 3'h1, 16'hbeef);
    gr(1'b0, 3'h3, 16'h00be);
    apb(1'b0, 12'h088, 32'h0);
    chk(rd, 32'hef, "pair low byte");
    done("banks");
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, A_PSW, 32'h81);
      apb(1'b1, A_SP, 32'hfe20);
      go(CMD_BRANCH, 16'h4000);
      go(j ? CMD_BREAK : CMD_INT_ACK, 16'h0010);
      chk({16'h0, pc_out}, 32'h0010, "entry pc");
      chk({31'h0, psw_out[7]}, 32'h0, "entry ie");
      chk({16'h0, sp_out}, 32'hfe1d, "entry sp");
      chk({8'h0, mem[16'hfe1f], mem[16'hfe1e], mem[16'hfe1d]}, 32'h814000, "saved");
      go(j ? CMD_BRK_RET : CMD_INT_RET, 16'h0);
      chk({16'h0, pc_out}, 32'h4000, "return pc");
      chk({24'h0, psw_out}, 32'h81, "return psw");
      chk({16'h0, sp_out}, 32'hfe20, "return sp");
    end
    go(CMD_SP_LOAD, 16'hfe10);
    chk({16'h0, sp_out}, 32'hfe10, "sp load");
    apb(1'b1, A_PSW, 32'h45);
    go(CMD_PUSH_PSW, 16'h0);
    chk({8'h0, mem[16'hfe0f], sp_out}, 32'h45fe0f, "push");
    apb(1'b1, A_PSW, 32'h0);
    go(CMD_POP_PSW, 16'h0);
    chk({8'h0, psw_out, sp_out}, 32'h45fe10, "pop");
    done("stack");
    print_verdict();
  end
endmodule : test_cpu_control_and_gp_registers
